// File: hw/sync_set_pkg.sv
// sync_set_pkg: command codes, field positions and types for the
// synchronous action set control block.
// assumes a single clock domain; no bus, plain ports only.
`default_nettype none
package sync_set_pkg;
  localparam int unsigned NUM_SETS       = 4;
  localparam logic [3:0]  CMD_ENABLE_HI  = 4'h8;
  localparam logic [3:0]  CMD_DISABLE_HI = 4'h9;
  localparam logic [3:0]  CMD_ACT_HI     = 4'ha;
  localparam logic [7:0]  CMD_ERR_CLEAR  = 8'h79;
  localparam logic [7:0]  CMD_SET_CFG0   = 8'h26;
  localparam logic [7:0]  CMD_OTHER_SET  = 8'h22;
  localparam int unsigned OTHER_ERRDIS_BIT = 7;
  localparam int unsigned CFG_REPEAT_BIT = 15;
  localparam int unsigned CFG_FACTOR_LSB = 0;
  localparam int unsigned CFG_FACTOR_W   = 4;
  localparam int unsigned IMASK_SET_LSB  = 12;
  localparam logic [3:0]  FACTOR_NOP     = 4'h0;
  localparam logic [3:0]  ENABLE_RST     = 4'h0;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
    logic [15:0] data;
  } cmd_s;

  typedef struct packed {
    logic       repeat_sel;
    logic [3:0] factor;
  } set_cfg_s;
endpackage
`default_nettype wire

// File: hw/set_cfg_store.sv
// set_cfg_store: per-set configuration words, registered read data.
// assumes writes and reads in the system clock domain.
`default_nettype none
module set_cfg_store
  import sync_set_pkg::*;
#(
  parameter int unsigned DEPTH = NUM_SETS
) (
  // clock and reset
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_rst,
  // write side
  input  wire logic                     i_wr_en,
  input  wire logic [1:0]               i_wr_idx,
  input  wire sync_set_pkg::set_cfg_s   i_wr_cfg,
  // read side, all entries
  output var sync_set_pkg::set_cfg_s [DEPTH-1:0] o_cfg
);
  if (DEPTH != 4) begin : g_depth_chk
    $error("set_cfg_store supports four sets only");
  end
  set_cfg_s [DEPTH-1:0] mem_r;
  set_cfg_s [DEPTH-1:0] mem_nxt;
  always_comb begin
    mem_nxt = mem_r;
    if (i_wr_en) begin
      mem_nxt[i_wr_idx] = i_wr_cfg;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      mem_r <= '0;
      o_cfg <= '0;
    end else begin
      mem_r <= mem_nxt;
      o_cfg <= mem_nxt;
    end
  end
endmodule
`default_nettype wire

// File: hw/sync_action_set_control.sv
// sync_action_set_control: enable flags, activation and interrupt for
// four synchronous action sets of one axis.
// assumes commands arrive as one-cycle strobes synchronous to the clock;
// factor events come from the action datapath outside this block.
`default_nettype none
////////////////////////////////////////////////////////////////////////
module sync_action_set_control
  import sync_set_pkg::*;
(
  // clock and reset
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rst,
  // host command strobe
  input  wire sync_set_pkg::cmd_s   i_cmd,
  // interrupt mask word
  input  wire logic [15:0]          i_interrupt_mask_word,
  // drive error flag level
  input  wire logic                 i_error_flag,
  // activation factor events per set
  input  wire logic [3:0]           i_factor_hit,
  // status readback page low bits
  output logic [3:0]                o_status_readback_page,
  // activation pulses, interrupts and error status
  output logic [3:0]                o_set_fire,
  output logic [3:0]                o_set_irq,
  output logic                      o_error_auto_disable,
  output logic                      o_error_lock
);
  ////////////////////////////////////////////////////////////////////
  // command decode
  logic       is_en;
  logic       is_dis;
  logic       is_act;
  logic       is_cfg;
  logic       is_other;
  logic       is_clr;
  logic [3:0] sel;
  assign sel      = i_cmd.code[3:0];
  assign is_en    = i_cmd.valid && i_cmd.code[7:4] == CMD_ENABLE_HI
                    && sel != 4'h0;
  assign is_dis   = i_cmd.valid && i_cmd.code[7:4] == CMD_DISABLE_HI
                    && sel != 4'h0;
  assign is_act   = i_cmd.valid && i_cmd.code[7:4] == CMD_ACT_HI
                    && sel != 4'h0;
  assign is_cfg   = i_cmd.valid
                    && 8'(i_cmd.code - CMD_SET_CFG0) < 8'(NUM_SETS);
  assign is_other = i_cmd.valid && i_cmd.code == CMD_OTHER_SET;
  assign is_clr   = i_cmd.valid && i_cmd.code == CMD_ERR_CLEAR;

  ////////////////////////////////////////////////////////////////////
  // configuration store
  logic [1:0] cfg_idx;
  set_cfg_s   cfg_wr;
  set_cfg_s [3:0] cfg;
  assign cfg_idx = 2'(i_cmd.code - CMD_SET_CFG0);
  assign cfg_wr.repeat_sel = i_cmd.data[CFG_REPEAT_BIT];
  assign cfg_wr.factor =
    i_cmd.data[CFG_FACTOR_LSB +: CFG_FACTOR_W];
  set_cfg_store #(.DEPTH(NUM_SETS)) u_cfg (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_wr_en   (is_cfg),
    .i_wr_idx  (cfg_idx),
    .i_wr_cfg  (cfg_wr),
    .o_cfg     (cfg)
  );

  ////////////////////////////////////////////////////////////////////
  // state
  logic [3:0] enable_r;
  logic [3:0] enable_nxt;
  logic       errdis_r;
  logic       errdis_nxt;
  logic       lock_r;
  logic       lock_nxt;
  logic       err_d_r;
  logic [3:0] fire_r;
  logic [3:0] fire_nxt;
  logic [3:0] irq_r;
  logic [3:0] irq_nxt;
  logic       err_rise;
  logic [3:0] fire_now;
  logic [3:0] once_clr;

  assign err_rise = i_error_flag && !err_d_r;

  always_comb begin
    fire_now   = '0;
    once_clr   = '0;
    enable_nxt = enable_r;
    errdis_nxt = errdis_r;
    lock_nxt   = lock_r;
    if (is_other) begin
      errdis_nxt = i_cmd.data[OTHER_ERRDIS_BIT];
    end
    for (int i = 0; i < NUM_SETS; i++) begin
      fire_now[i] = enable_r[i] &&
                    (i_factor_hit[i] && cfg[i].factor != FACTOR_NOP
                     || is_act && sel[i]);
      once_clr[i] = fire_now[i] && !cfg[i].repeat_sel;
    end
    enable_nxt = enable_nxt & ~once_clr;
    if (is_dis) begin
      enable_nxt = enable_nxt & ~sel;
    end
    if (is_en && !lock_r) begin
      enable_nxt = enable_nxt | sel;
    end
    if (is_clr) begin
      lock_nxt = 1'b0;
    end
    if (err_rise && errdis_r) begin
      enable_nxt = '0;
      lock_nxt   = 1'b1;
    end
    fire_nxt = fire_now;
    irq_nxt  = fire_now & i_interrupt_mask_word[IMASK_SET_LSB +: 4];
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      enable_r <= ENABLE_RST;
      errdis_r <= 1'b0;
      lock_r   <= 1'b0;
      err_d_r  <= 1'b0;
      fire_r   <= '0;
      irq_r    <= '0;
    end else begin
      enable_r <= enable_nxt;
      errdis_r <= errdis_nxt;
      lock_r   <= lock_nxt;
      err_d_r  <= i_error_flag;
      fire_r   <= fire_nxt;
      irq_r    <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs
  assign o_status_readback_page = enable_r;
  assign o_set_fire             = fire_r;
  assign o_set_irq              = irq_r;
  assign o_error_auto_disable   = errdis_r;
  assign o_error_lock           = lock_r;

  ////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  dis_clears_a: assert property (
    is_dis |=> (enable_r & $past(sel)) == 4'h0)
    else $error("disable left a selected flag set");
  no_fire_dis_a: assert property (
    (i_factor_hit & ~enable_r) != 4'h0 && !is_act
    |=> (fire_r & $past(~enable_r)) == 4'h0)
    else $error("disabled set fired");
  en_sets_a: assert property (
    is_en && !lock_r && !err_rise
    |=> (enable_r & $past(sel)) == $past(sel))
    else $error("enable did not set flags");
  keep_unsel_a: assert property (
    (is_en || is_dis) && !err_rise && fire_now == 4'h0
    |=> (enable_r & $past(~sel)) == ($past(enable_r) & $past(~sel)))
    else $error("unselected flag changed");
  err_clear_a: assert property (
    err_rise && errdis_r |=> enable_r == 4'h0 && lock_r)
    else $error("error did not clear flags");
  once_a: assert property (
    fire_now[0] && !cfg[0].repeat_sel && !is_en |=> !enable_r[0])
    else $error("single-shot set stayed enabled");
  repeat_a: assert property (
    fire_now[2] && cfg[2].repeat_sel && !is_dis && !err_rise
    |=> enable_r[2])
    else $error("repeat set lost its enable");
  act_fire_a: assert property (
    is_act |=> (fire_r & $past(sel & enable_r)) == $past(sel & enable_r))
    else $error("activation missed a set");
  act_only_sel_a: assert property (
    is_act && i_factor_hit == 4'h0 |=> (fire_r & $past(~sel)) == 4'h0)
    else $error("unselected set activated");
  cfg_last_a: assert property (
    i_cmd.valid && i_cmd.code == CMD_SET_CFG0 + 8'(NUM_SETS - 1)
    |=> cfg[NUM_SETS-1].factor
        == $past(i_cmd.data[CFG_FACTOR_LSB +: CFG_FACTOR_W]))
    else $error("last set configuration not stored");
  irq_a: assert property (
    fire_now[1] && i_interrupt_mask_word[13] |=> o_set_irq[1])
    else $error("masked interrupt missing");
  irq_off_a: assert property (
    fire_now[3] && !i_interrupt_mask_word[15] |=> !o_set_irq[3])
    else $error("interrupt raised while masked off");
  lock_a: assert property (
    lock_r && !is_clr && !is_dis
    |=> $stable(lock_r) && (enable_r & ~$past(enable_r)) == 4'h0)
    else $error("enable accepted while locked");

  // covers
  act_c: cover property (is_act ##1 o_set_fire != 4'h0);
  factor_c: cover property (i_factor_hit[2] && enable_r[2]);
  lock_c: cover property (lock_r ##[1:20] is_clr);
  irq_c: cover property (o_set_irq[3]);
  once_c: cover property (fire_now[0] && !cfg[0].repeat_sel);
endmodule
`default_nettype wire

// File: test/host_cmd_model.sv
// host_cmd_model: host side issuing one-cycle command strobes.
// assumes one shared clock; caller waits for send to return.
`default_nettype none
module host_cmd_model (
  // clock
  input  wire logic              i_sys_clk,
  // command strobe
  output var sync_set_pkg::cmd_s o_cmd
);
  timeunit 1ns;
  timeprecision 100ps;
  import sync_set_pkg::*;
  initial o_cmd = '0;
  ////////////////////////////////////////////////////////////////////
  // strobe one cycle, then lines released to the inverse
  task automatic send(input logic [7:0] code, input logic [15:0] data);
    @(posedge i_sys_clk);
    #1 o_cmd = '{1'b1, code, data};
    @(posedge i_sys_clk);
    #1 o_cmd = '{1'b0, ~code, ~data};
  endtask
endmodule
`default_nettype wire

// File: test/testbench.sv
// testbench: scenario tasks for the action set control block.
// assumes the host model drives every command strobe.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import sync_set_pkg::*;
  logic        i_sys_clk = 1'b0;
  logic        i_rst = 1'b1;
  cmd_s        cmd;
  logic [15:0] mask = 16'h0;
  logic        err = 1'b0;
  logic [3:0]  hit = 4'h0;
  logic [3:0]  status;
  logic [3:0]  fire;
  logic [3:0]  irq;
  logic        auto_dis;
  logic        lock;
  int          mismatches = 0;
  int          compares = 0;
  host_cmd_model HOST (.i_sys_clk(i_sys_clk), .o_cmd(cmd));
  sync_action_set_control DUT (
    .i_sys_clk             (i_sys_clk),
    .i_rst                 (i_rst),
    .i_cmd                 (cmd),
    .i_interrupt_mask_word (mask),
    .i_error_flag          (err),
    .i_factor_hit          (hit),
    .o_status_readback_page(status),
    .o_set_fire            (fire),
    .o_set_irq             (irq),
    .o_error_auto_disable  (auto_dis),
    .o_error_lock          (lock)
  );
  initial forever #10 i_sys_clk = ~i_sys_clk;
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [3:0] exp, input logic [3:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic do_cmd(input logic [7:0] c, input logic [15:0] d,
                        input logic [3:0] st);
    HOST.send(c, d);
    chk(st, status);
  endtask
  task automatic pulse_hit(input logic [3:0] v);
    @(posedge i_sys_clk);
    #1 hit = v;
    @(posedge i_sys_clk);
    #1 hit = 4'h0;
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_flags();
    do_cmd(8'h83, 16'h0, 4'h3);
    do_cmd(8'h84, 16'h0, 4'h7);
    do_cmd(8'h92, 16'h0, 4'h5);
    do_cmd(8'h90, 16'h0, 4'h5);
    do_cmd(8'h9f, 16'h0, 4'h0);
  endtask
  task automatic t_activate();
    for (int i = 0; i < 4; i++) begin
      do_cmd(8'h26 + 8'(i), 16'h8000, 4'h0);
    end
    do_cmd(8'h85, 16'h0, 4'h5);
    mask = 16'hf000;
    HOST.send(8'ha5, 16'h0);
    chk(4'h5, fire);
    chk(4'h5, irq);
    chk(4'h5, status);
    @(posedge i_sys_clk);
    #1 chk(4'h0, fire);
    mask = 16'h4000;
    HOST.send(8'ha7, 16'h0);
    chk(4'h5, fire);
    chk(4'h4, irq);
  endtask
  task automatic t_single();
    do_cmd(8'h26, 16'h0001, 4'h5);
    do_cmd(8'h28, 16'h8002, 4'h5);
    pulse_hit(4'h7);
    chk(4'h5, fire);
    chk(4'h4, status);
    pulse_hit(4'h1);
    chk(4'h0, fire);
    pulse_hit(4'h4);
    chk(4'h4, fire);
    chk(4'h4, status);
  endtask
  task automatic t_error();
    do_cmd(8'h22, 16'h0080, 4'h4);
    chk(4'h1, {3'h0, auto_dis});
    do_cmd(8'h8f, 16'h0, 4'hf);
    @(posedge i_sys_clk);
    #1 err = 1'b1;
    @(posedge i_sys_clk);
    #1 chk(4'h0, status);
    chk(4'h1, {3'h0, lock});
    do_cmd(8'h8f, 16'h0, 4'h0);
    do_cmd(8'h79, 16'h0, 4'h0);
    chk(4'h0, {3'h0, lock});
    do_cmd(8'h8f, 16'h0, 4'hf);
  endtask
  task automatic t_reset();
    @(posedge i_sys_clk);
    #1 i_rst = 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1 i_rst = 1'b0;
    chk(4'h0, status);
    chk(4'h0, {3'h0, auto_dis});
    do_cmd(8'h81, 16'h0, 4'h1);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge i_sys_clk);
    #1 i_rst = 1'b0;
    chk(4'h0, status);
    t_flags();
    t_activate();
    t_single();
    t_error();
    t_reset();
    print_verdict();
  end
  initial begin
    #40000;
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
